// [design/rpc_codec.sv]
// Remote PHY packet codec: command encoder and reply decoder with APB registers
`timescale 1ns/1ns
module rpc_codec
    import rpc_pkg::*;
(
    input wire logic ref_clk_in, // 250 MHz clock
    input wire logic sys_rst_in, // Sync reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic [31:0] tx_quad_out, // Quadlet to PHY
    output logic tx_valid_out, // Quadlet valid
    input wire logic tx_ready_in, // PHY takes quadlet
    input wire logic [31:0] rx_quad_in, // Quadlet from PHY
    input wire logic rx_valid_in, // Quadlet valid
    input wire logic rx_last_in, // Last quadlet of packet
    output logic rx_ready_out, // Back-pressure to PHY
    input wire logic [4:0] rx_ack_in, // Ack sent for packet
    input wire logic [1:0] rx_speed_in, // Receive speed code
    input wire logic [1:0] rx_pad_in, // Pad bytes appended
    input wire logic rx_self_id_in // Packet is self-ID
);
    logic apb_acc;
    logic apb_wr;
    logic apb_rd;
    logic apb_setup;
    logic send_req;
    logic tx_busy;
    logic [31:0] first_quad;
    rpc_cmd_s cmd_q;
    rpc_cmd_s cmd_wr;
    rpc_tx_state_e tx_state_q;
    logic [31:0] tx_quad_q;
    logic sent_q;

    rpc_rx_state_e rx_state_q;
    logic [31:0] rx_first_q;
    rpc_rx_attr_s rx_attr_q;
    logic [31:0] rd_word;
    logic [31:0] prdata_q;
    logic pop_armed_q;
    logic [7:0] drop_cnt_q;
    logic [31:0] push_word;
    logic push_valid;
    logic push_ready;
    logic push_tok_q;
    rpc_token_s token;
    logic [31:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [2:0] fifo_level;
    logic rx_take;
    logic pair_ok;
    logic type_ok;

    assign apb_acc = psel && penable;
    assign apb_wr = apb_acc && pwrite;
    assign apb_rd = apb_acc && !pwrite;
    assign apb_setup = psel && !penable;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Command encoder
    assign tx_busy = (tx_state_q != RPC_TX_IDLE);
    assign send_req = apb_wr && (paddr == RPC_OFS_CMD_CTRL) && pwdata[31] && !tx_busy;
    // Built from the write itself; only loaded on the start edge, where both agree
    assign cmd_wr = pwdata[$bits(rpc_cmd_s)-1:0];
    always_comb
    begin
        first_quad = RPC_RST_WORD;
        first_quad[RPC_ID_MSB -: 2] = RPC_PHY_PKT_ID;
        first_quad[RPC_NODE_LSB +: 6] = cmd_wr.target_node_number;
        first_quad[RPC_TYPE_LSB +: 4] = RPC_TYPE_COMMAND;
        first_quad[RPC_PAGE_LSB +: 3] = cmd_wr.page;
        first_quad[RPC_PORT_LSB +: 4] = cmd_wr.port;
        first_quad[RPC_MARK_LSB +: 4] = RPC_EXT_MARK;
        first_quad[2:0] = cmd_wr.remote_operation_code;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            cmd_q <= '0;
        end
        else if (apb_wr && (paddr == RPC_OFS_CMD_CTRL) && !tx_busy)
        begin
            // Codes 3 and 7 have no meaning; pass them through unchanged
            cmd_q <= pwdata[$bits(rpc_cmd_s)-1:0];
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            tx_state_q <= RPC_TX_IDLE;
            tx_quad_q <= RPC_RST_WORD;
        end
        else
        begin
            unique case (tx_state_q)
                RPC_TX_IDLE:
                begin
                    if (send_req)
                    begin
                        tx_state_q <= RPC_TX_FIRST;
                        tx_quad_q <= first_quad;
                    end
                end
                RPC_TX_FIRST:
                begin
                    if (tx_ready_in)
                    begin
                        tx_state_q <= RPC_TX_SECOND;
                        tx_quad_q <= ~tx_quad_q;
                    end
                end
                RPC_TX_SECOND:
                begin
                    if (tx_ready_in)
                    begin
                        tx_state_q <= RPC_TX_IDLE;
                        tx_quad_q <= RPC_RST_WORD;
                    end
                end
            endcase
        end
    end

    // Quadlet comes from a flop loaded at the start edge, so it is ready in the first cycle
    assign tx_valid_out = tx_busy;
    assign tx_quad_out = tx_quad_q;

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            sent_q <= 1'b0;
        end
        else if ((tx_state_q == RPC_TX_SECOND) && tx_ready_in)
        begin
            sent_q <= 1'b1; // Set wins over clear below
        end
        else if (apb_wr && (paddr == RPC_OFS_CMD_STAT) && pwdata[0])
        begin
            sent_q <= 1'b0;
        end
    end

    // Reply decoder: pairs quadlets, checks inverse, prefixes a token
    assign rx_ready_out = (rx_state_q != RPC_RX_PUSH);
    assign rx_take = rx_valid_in && rx_ready_out;
    assign pair_ok = (rx_quad_in == ~rx_first_q);
    assign type_ok = (rx_first_q[RPC_ID_MSB -: 2] == RPC_PHY_PKT_ID)
        && ((rx_first_q[RPC_TYPE_LSB +: 4] == RPC_TYPE_BASE_RD)
        || (rx_first_q[RPC_TYPE_LSB +: 4] == RPC_TYPE_PAGED_RD));

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            rx_state_q <= RPC_RX_FIRST;
            rx_first_q <= RPC_RST_WORD;
            rx_attr_q <= '0;
            push_tok_q <= 1'b1;
            drop_cnt_q <= 8'h00;
        end
        else
        begin
            unique case (rx_state_q)
                RPC_RX_FIRST:
                begin
                    if (rx_take && !rx_last_in)
                    begin
                        rx_first_q <= rx_quad_in;
                        rx_attr_q <= {rx_ack_in, rx_pad_in, rx_speed_in, rx_self_id_in};
                        rx_state_q <= RPC_RX_SECOND;
                    end
                    else if (rx_take)
                    begin
                        drop_cnt_q <= drop_cnt_q + 8'h01;
                    end
                end
                RPC_RX_SECOND:
                begin
                    if (rx_take)
                    begin
                        if (pair_ok && type_ok && rx_last_in)
                        begin
                            rx_state_q <= RPC_RX_PUSH;
                            push_tok_q <= 1'b1;
                        end
                        else
                        begin
                            drop_cnt_q <= drop_cnt_q + 8'h01;
                            rx_state_q <= RPC_RX_FIRST;
                        end
                    end
                end
                RPC_RX_PUSH:
                begin
                    if (push_ready)
                    begin
                        push_tok_q <= 1'b0;
                        if (!push_tok_q)
                        begin
                            rx_state_q <= RPC_RX_FIRST;
                        end
                    end
                end
            endcase
        end
    end

    always_comb
    begin
        token = '0;
        token.quadlet_count = RPC_REPLY_QUADS;
        token.self_id_flag = rx_attr_q.self_id;
        token.phy_pkt_flag = 1'b1;
        token.acknowledge_code = rx_attr_q.acknowledge_code;
        token.pad_count = rx_attr_q.pad_count;
        token.speed_code = rx_attr_q.speed_code;
    end

    // Reserved low byte of the reply body is cleared, it carries nothing
    assign push_word = push_tok_q ? token : {rx_first_q[31:8], 8'h00};
    assign push_valid = (rx_state_q == RPC_RX_PUSH);
    assign fifo_pop = apb_rd && pop_armed_q;

    rpc_fifo #(
        .WIDTH(RPC_FIFO_WIDTH),
        .DEPTH(RPC_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_data_in(push_word),
        .wr_valid_in(push_valid),
        .wr_ready_out(push_ready),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(fifo_pop),
        .level_out(fifo_level)
    );

    // Read word is latched in the setup cycle so prdata comes straight from a flop
    always_comb
    begin
        rd_word = RPC_UNMAPPED_RD;
        unique case (paddr)
            RPC_OFS_CMD_CTRL: rd_word = {16'h0000, cmd_q};
            RPC_OFS_CMD_STAT: rd_word = {30'h0, tx_busy, sent_q};
            RPC_OFS_RX_DATA: rd_word = fifo_valid ? fifo_data : RPC_UNMAPPED_RD;
            RPC_OFS_RX_STAT: rd_word = {21'h0, drop_cnt_q, fifo_level};
            RPC_OFS_RX_INFO: rd_word = {18'h0, rx_first_q[RPC_PAGE_LSB +: 3],
                rx_first_q[RPC_PORT_LSB +: 4], rx_first_q[RPC_REG_LSB +: 3], 4'h0};
            default: rd_word = RPC_UNMAPPED_RD;
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            prdata_q <= RPC_UNMAPPED_RD;
            pop_armed_q <= 1'b0;
        end
        else if (apb_setup && !pwrite)
        begin
            prdata_q <= rd_word;
            // Pop only the word shown; one pushed meanwhile stays queued
            pop_armed_q <= (paddr == RPC_OFS_RX_DATA) && fifo_valid;
        end
        else
        begin
            prdata_q <= RPC_UNMAPPED_RD;
            pop_armed_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
endmodule : rpc_codec

// [design/rpc_fifo.sv]
// Small valid/ready FIFO used for decoded receive words
`timescale 1ns/1ns
module rpc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk_in, // Clock
    input wire logic sys_rst_in, // Sync reset, high
    input wire logic [WIDTH-1:0] wr_data_in, // Write data
    input wire logic wr_valid_in, // Write valid
    output logic wr_ready_out, // Not full
    output logic [WIDTH-1:0] rd_data_out, // Head word
    output logic rd_valid_out, // Not empty
    input wire logic rd_ready_in, // Pop
    output logic [$clog2(DEPTH):0] level_out // Occupancy
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
    assign rd_valid_out = (count_q != '0);
    assign push = wr_valid_in && wr_ready_out;
    assign pop = rd_valid_out && rd_ready_in;
    assign rd_data_out = mem_q[rd_ptr_q];
    assign level_out = count_q;

    always_ff @(posedge ref_clk_in)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= wr_data_in;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
            end
            if (push && !pop)
            begin
                count_q <= count_q + (AW+1)'(1);
            end
            else if (pop && !push)
            begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end
endmodule : rpc_fifo

// [design/rpc_pkg.sv]
// Package for the remote PHY packet codec: field layout, codes and register map
package rpc_pkg;
    // APB register byte offsets
    localparam logic [7:0] RPC_OFS_CMD_CTRL = 8'h00;
    localparam logic [7:0] RPC_OFS_CMD_STAT = 8'h04;
    localparam logic [7:0] RPC_OFS_RX_DATA = 8'h08;
    localparam logic [7:0] RPC_OFS_RX_STAT = 8'h0c;
    localparam logic [7:0] RPC_OFS_RX_INFO = 8'h10;
    localparam logic [31:0] RPC_RST_WORD = 32'h0000_0000;
    localparam logic [31:0] RPC_UNMAPPED_RD = 32'h0000_0000;

    // Packet quadlet fields
    localparam int RPC_ID_MSB = 31;
    localparam int RPC_NODE_LSB = 24;
    localparam int RPC_TYPE_LSB = 18;
    localparam int RPC_PAGE_LSB = 15;
    localparam int RPC_PORT_LSB = 11;
    localparam int RPC_REG_LSB = 8;
    localparam int RPC_MARK_LSB = 4;
    localparam logic [1:0] RPC_PHY_PKT_ID = 2'h0;
    localparam logic [3:0] RPC_TYPE_BASE_RD = 4'h1;
    localparam logic [3:0] RPC_TYPE_PAGED_RD = 4'h5;
    localparam logic [3:0] RPC_TYPE_COMMAND = 4'h8;
    localparam logic [3:0] RPC_EXT_MARK = 4'he;

    // Token fields
    localparam int RPC_TOK_SIZE_LSB = 16;
    localparam int RPC_TOK_S_BIT = 15;
    localparam int RPC_TOK_P_BIT = 14;
    localparam int RPC_TOK_ACK_LSB = 8;
    localparam int RPC_TOK_PAD_LSB = 6;
    localparam int RPC_TOK_SPD_LSB = 4;
    localparam logic [13:0] RPC_REPLY_QUADS = 14'h0002;

    // Speed codes
    localparam logic [1:0] RPC_SPD_100 = 2'h0;
    localparam logic [1:0] RPC_SPD_200 = 2'h1;
    localparam logic [1:0] RPC_SPD_400 = 2'h2;

    // Remote operation codes
    localparam logic [2:0] RPC_OP_NOP = 3'h0;
    localparam logic [2:0] RPC_OP_DISABLE = 3'h1;
    localparam logic [2:0] RPC_OP_SUSPEND = 3'h2;
    localparam logic [2:0] RPC_OP_CLR_FAULT = 3'h4;
    localparam logic [2:0] RPC_OP_ENABLE = 3'h5;
    localparam logic [2:0] RPC_OP_RESUME = 3'h6;

    localparam int RPC_FIFO_WIDTH = 32;
    localparam int RPC_FIFO_DEPTH = 4;

    typedef struct packed {
        logic [1:0] rsvd_hi;
        logic [13:0] quadlet_count;
        logic self_id_flag;
        logic phy_pkt_flag;
        logic rsvd_mid;
        logic [4:0] acknowledge_code;
        logic [1:0] pad_count;
        logic [1:0] speed_code;
        logic [3:0] rsvd_lo;
    } rpc_token_s;

    typedef struct packed {
        logic [5:0] target_node_number;
        logic [2:0] page;
        logic [3:0] port;
        logic [2:0] remote_operation_code;
    } rpc_cmd_s;

    typedef struct packed {
        logic [4:0] acknowledge_code;
        logic [1:0] pad_count;
        logic [1:0] speed_code;
        logic self_id;
    } rpc_rx_attr_s;

    typedef enum logic [2:0] {
        RPC_TX_IDLE = 3'b001,
        RPC_TX_FIRST = 3'b010,
        RPC_TX_SECOND = 3'b100
    } rpc_tx_state_e;

    typedef enum logic [2:0] {
        RPC_RX_FIRST = 3'b001,
        RPC_RX_SECOND = 3'b010,
        RPC_RX_PUSH = 3'b100
    } rpc_rx_state_e;
endpackage : rpc_pkg

// [test/rpc_codec_asserts.sv]
// Port checker for the remote PHY packet codec
`timescale 1ns/1ns
module rpc_codec_asserts (
    input wire logic ref_clk_in, // Clock
    input wire logic sys_rst_in, // Reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic [31:0] tx_quad_out, // Quadlet out
    input wire logic tx_valid_out, // Quadlet valid
    input wire logic tx_ready_in, // PHY takes
    input wire logic [31:0] rx_quad_in, // Quadlet in
    input wire logic rx_valid_in, // In valid
    input wire logic rx_last_in, // Last quadlet
    input wire logic rx_ready_out // Back-pressure
);
    default clocking dc @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    logic [31:0] prev_q;
    logic [31:0] wd_q;
    logic good;
    // A well-formed reply pair must drop rx_ready_out (enter the push state) within 200 cycles
    assign good = rx_valid_in && rx_ready_out && rx_last_in && rx_quad_in == ~prev_q
        && prev_q[31:30] == 2'h0 && (prev_q[21:18] == 4'h1 || prev_q[21:18] == 4'h5);
    always_ff @(posedge ref_clk_in)
    begin
        if (rx_valid_in && rx_ready_out)
            prev_q <= rx_quad_in;
    end
    always_ff @(posedge ref_clk_in)
    begin
        wd_q <= pwdata;
    end
    a_tx_start_fields:
    assert property (psel && penable && pwrite && paddr == 8'h00 && pwdata[31] && !tx_valid_out
        |=> tx_valid_out && {tx_quad_out[29:24], tx_quad_out[17:11], tx_quad_out[2:0]}
        == wd_q[15:0]) else $error("command fields differ from register write");
    a_tx_header:
    assert property (tx_valid_out && tx_quad_out[7:4] == 4'he |-> tx_quad_out[31:30] == 2'h0
        && tx_quad_out[23:18] == 6'h08 && tx_quad_out[10:8] == 3'h0 && !tx_quad_out[3])
        else $error("command header fields wrong");
    a_tx_inverse:
    assert property (tx_valid_out && tx_ready_in && tx_quad_out[7:4] == 4'he
        |=> tx_valid_out && tx_quad_out == ~$past(tx_quad_out))
        else $error("second quadlet is not the inverse");
    a_tx_pair_end:
    assert property (tx_valid_out && tx_ready_in && tx_quad_out[7:4] == 4'h1 |=> !tx_valid_out)
        else $error("packet longer than two quadlets");
    a_tx_hold_quad:
    assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_quad_out))
        else $error("quadlet changed before acceptance");
    a_rx_reply_push:
    assert property (good |-> ##[1:200] !rx_ready_out) else $error("reply never decoded");
    a_rx_push_two:
    assert property ($fell(rx_ready_out) |-> !rx_ready_out [*2])
        else $error("token and body not both pushed");
    a_prdata_idle:
    assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read access");
endmodule : rpc_codec_asserts
bind rpc_codec rpc_codec_asserts u_rpc_codec_asserts (.*);

// [test/rpc_codec_test.sv]
// Self-checking bench for the remote PHY packet codec
`timescale 1ns/1ns
module rpc_codec_test;
    import rpc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel, penable, pwrite, stall, pready, pslverr;
    logic txv, txr, rxv, rxl, rxr, sid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, txd, rxd, rd, q0;
    logic [4:0] ack;
    logic [1:0] spd, pad;
    int fails = 0, checks = 0, cyc = 0;
    logic [2:0] ops [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    rpc_codec u_rpc_codec (.ref_clk_in(clk), .sys_rst_in(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_quad_out(txd), .tx_valid_out(txv), .tx_ready_in(txr),
        .rx_quad_in(rxd), .rx_valid_in(rxv), .rx_last_in(rxl), .rx_ready_out(rxr),
        .rx_ack_in(ack), .rx_speed_in(spd), .rx_pad_in(pad), .rx_self_id_in(sid));
    rpc_phy_model u_rpc_phy_model (.clk_in(clk), .rst_in(rst), .stall_in(stall),
        .tx_quad_in(txd), .tx_valid_in(txv), .tx_ready_out(txr), .rx_quad_out(rxd),
        .rx_valid_out(rxv), .rx_last_out(rxl), .rx_ready_in(rxr), .rx_ack_out(ack),
        .rx_speed_out(spd), .rx_pad_out(pad), .rx_self_id_out(sid));
    initial
    begin
        forever #2 clk = ~clk;
    end
    task summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fails++;
            summarize();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer, then an idle cycle so strobes never double-assign
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Reply first quadlet with nonzero reserved byte
    function automatic logic [31:0] rq(input int j);
        return {2'h0, 6'(j + 1), 2'h0, j[0] ? 4'h5 : 4'h1, 3'(j), 4'(j + 2), 3'(7 - j), 8'ha5};
    endfunction : rq
    initial
    begin
        {psel, penable, pwrite, stall, paddr, pwdata} = 44'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b1, 8'h14, 32'hffff_ffff);
        for (int a = 0; a < 24; a += 4)
        begin
            apb(1'b0, 8'(a), 32'h0);
            chk(rd, RPC_RST_WORD);
            chk({30'h0, pready, pslverr}, 32'h2);
        end
        for (int i = 0; i < 6; i++)
        begin
            logic [15:0] f;
            f = {6'h3f ^ 6'(i), 3'(i), 4'hf - 4'(i), ops[i]};
            stall <= (i == 1);
            apb(1'b1, RPC_OFS_CMD_CTRL, {16'h8000, f});
            if (i == 1)
            begin
                apb(1'b1, RPC_OFS_CMD_CTRL, 32'h8000_ffff);
                apb(1'b0, RPC_OFS_CMD_STAT, 32'h0);
                chk(rd, 32'h2);
                apb(1'b0, RPC_OFS_CMD_CTRL, 32'h0);
                chk({16'h0, rd[15:0]}, {16'h0, f});
                stall <= 1'b0;
            end
            rd = 32'h0;
            for (int n = 0; n < 40 && rd[0] !== 1'b1; n++)
                apb(1'b0, RPC_OFS_CMD_STAT, 32'h0);
            chk(rd, 32'h1);
            q0 = {2'h0, f[15:10], 2'h0, RPC_TYPE_COMMAND, f[9:3], 3'h0, RPC_EXT_MARK, 1'b0, f[2:0]};
            chk(32'(u_rpc_phy_model.txq.size()), 32'h2);
            chk(u_rpc_phy_model.txq[0], q0);
            chk(u_rpc_phy_model.txq[1], ~q0);
            u_rpc_phy_model.txq.delete();
            apb(1'b1, RPC_OFS_CMD_STAT, 32'h1);
        end
        // Third reply stalls until a word is popped from the full FIFO
        for (int j = 0; j < 3; j++)
            u_rpc_phy_model.send(rq(j), ~rq(j), 5'(7 * j + 3), 2'(j), 2'(3 - j), j == 1);
        apb(1'b0, RPC_OFS_RX_STAT, 32'h0);
        chk(rd, 32'h4);
        for (int j = 0; j < 3; j++)
        begin
            q0 = rq(j);
            apb(1'b0, RPC_OFS_RX_DATA, 32'h0);
            chk(rd, {2'h0, 14'h2, j == 1, 1'b1, 1'b0, 5'(7 * j + 3), 2'(3 - j), 2'(j), 4'h0});
            apb(1'b0, RPC_OFS_RX_DATA, 32'h0);
            chk(rd, {q0[31:8], 8'h00});
        end
        apb(1'b0, RPC_OFS_RX_INFO, 32'h0);
        chk(rd, {18'h0, q0[17:8], 4'h0});
        u_rpc_phy_model.send(rq(0), rq(0), 5'h1, 2'h0, 2'h0, 1'b0);
        u_rpc_phy_model.send(rq(1) | 32'h4000_0000, ~(rq(1) | 32'h4000_0000), 5'h1, 2'h0, 2'h0,
            1'b0);
        apb(1'b0, RPC_OFS_RX_STAT, 32'h0);
        chk(rd, 32'h10);
        apb(1'b0, RPC_OFS_RX_DATA, 32'h0);
        chk(rd, 32'h0);
        summarize();
    end
endmodule : rpc_codec_test

// [test/rpc_phy_model.sv]
// Behavioural PHY: takes command quadlets, sends reply quadlets
`timescale 1ns/1ns
module rpc_phy_model (
    input wire logic clk_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic stall_in, // Hold off quadlets
    input wire logic [31:0] tx_quad_in, // From codec
    input wire logic tx_valid_in, // From codec
    output logic tx_ready_out, // To codec
    output logic [31:0] rx_quad_out, // To codec
    output logic rx_valid_out, // Valid
    output logic rx_last_out, // Last of pair
    input wire logic rx_ready_in, // Codec takes
    output logic [4:0] rx_ack_out, // Ack code
    output logic [1:0] rx_speed_out, // Speed code
    output logic [1:0] rx_pad_out, // Pad bytes
    output logic rx_self_id_out // Self-ID
);
    logic [31:0] txq [$];
    initial
    begin
        tx_ready_out = 1'b0;
        rx_quad_out = 32'h0;
        {rx_valid_out, rx_last_out, rx_ack_out, rx_speed_out, rx_pad_out} = 11'h0;
        rx_self_id_out = 1'b0;
    end
    always @(posedge clk_in)
    begin
        tx_ready_out <= !rst_in && !stall_in;
        if (tx_valid_in && tx_ready_out && !rst_in)
            txq.push_back(tx_quad_in);
    end
    task send(input logic [31:0] q0, input logic [31:0] q1, input logic [4:0] ack,
        input logic [1:0] spd, input logic [1:0] pad, input logic sid);
        rx_quad_out <= q0;
        rx_valid_out <= 1'b1;
        rx_last_out <= 1'b0;
        rx_ack_out <= ack;
        rx_speed_out <= spd;
        rx_pad_out <= pad;
        rx_self_id_out <= sid;
        do @(posedge clk_in); while (rx_ready_in !== 1'b1);
        rx_quad_out <= q1;
        rx_last_out <= 1'b1;
        do @(posedge clk_in); while (rx_ready_in !== 1'b1);
        rx_valid_out <= 1'b0;
        rx_last_out <= 1'b0;
        // Released line shows the inverted quadlet and ack; speed, pad and self-ID keep their values
        rx_quad_out <= ~q1;
        rx_ack_out <= ~ack;
        @(posedge clk_in);
    endtask : send
endmodule : rpc_phy_model
